// *** core/divert_pkg.sv ***
// Constants and cell layout for the special-routing cell diversion block
package divert_pkg;

  // Logical port number width and count
  localparam int PORT_W = 5;
  localparam int PORTS = 32;
  // Queue length width of the processor port queue
  localparam int QLEN_W = 16;
  // Depth of the cell buffer in front of the decision stage
  localparam int FIFO_DEPTH = 16;

  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_FILTER = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_EFCI_THR = 8'h0C;
  localparam logic [7:0] ADDR_DISC_THR = 8'h10;
  localparam logic [7:0] ADDR_DIV_COUNT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Field positions in diversion_port_config_register
  localparam int CPU_PORT_LSB = 0;
  localparam int DIVERT_EN_BIT = 8;
  localparam int APPEND_SCOPE_BIT = 9;
  // Field position of efci_vc_only_select in global_mode_register_zero
  localparam int EFCI_VC_ONLY_BIT = 0;
  // Field positions in the status register
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_CONG_BIT = 8;
  localparam int STAT_OVER_BIT = 9;

  // Values after reset
  localparam logic [PORT_W-1:0] CPU_PORT_RST = 5'h00;
  localparam logic [2:0] PTF_RST = 3'h7;
  localparam logic [QLEN_W-1:0] EFCI_THR_RST = 16'hFFFF;
  localparam logic [QLEN_W-1:0] DISC_THR_RST = 16'hFFFF;

  // PTI codes: congestion bit position and the first filter code allowed
  localparam int PTI_EFCI_BIT = 1;
  localparam logic [2:0] PTI_FILTER_MIN = 3'h4;

  // One cell descriptor as it moves through the buffer
  typedef struct packed {
    logic [PORT_W-1:0] in_port;  // Logical input port
    logic [11:0] vpi;            // Header VPI as received
    logic [15:0] vci;            // Header VCI as received
    logic [2:0] pti;             // Payload type
    logic clp;                   // Cell loss priority
    logic flag;                  // divert_to_cpu_flag from the translation table
    logic vp_conn;               // vp_connection_flag
    logic user_chan;             // User channel, else pre-defined
    logic rm_cell;               // Resource management cell
    logic [PORTS-1:0] dest;      // Ordinary destination mask
    logic [11:0] xvpi;           // Translated VPI
    logic [15:0] xvci;           // Translated VCI
  } cell_type;

endpackage

// *** core/cell_diversion.sv ***
// Cell buffer and special-routing diversion stage with its APB registers
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO with registered full and empty flags
module cell_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
    logic empty;
  } fifo_state_type;

  fifo_state_type s_r;
  fifo_state_type s_nxt;
  logic push;
  logic pop;

  // Flags come from flops so the upstream ready is clean
  assign wr_ready = ~s_r.full;
  assign rd_valid = ~s_r.empty;
  assign rd_data = s_r.mem[s_r.rd_ptr];
  assign level = s_r.count;
  assign push = wr_valid & ~s_r.full;
  assign pop = rd_ready & ~s_r.empty;

  // Pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = wr_data;
      s_nxt.wr_ptr = AW'(s_r.wr_ptr + 1'b1);
    end
    if (pop) begin
      s_nxt.rd_ptr = AW'(s_r.rd_ptr + 1'b1);
    end
    // Push and pop together leave the count alone
    if (push && !pop) begin
      s_nxt.count = (AW + 1)'(s_r.count + 1'b1);
    end else if (pop && !push) begin
      s_nxt.count = (AW + 1)'(s_r.count - 1'b1);
    end
    s_nxt.full = (s_nxt.count == (AW + 1)'(DEPTH));
    s_nxt.empty = (s_nxt.count == '0);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{default: '0, empty: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// Overview of operation
// - Single cast: matching cell goes to processor port
// - Multicast: matching cell reaches processor port only
// - Pre-defined channel diverts when table flag set
// - User channel diverts when PTI equals filter
// - Filter diversion only on VC connections
// - Cells from processor port never diverted
// - Processor port number comes from config register
// - Diverted cell keeps input VPI and VCI
// - Mode clear: EFCI mark VC and VP cells
// - Mode set: EFCI mark VC cells only
// - Diverted RM cell gets no CI/NI marking
// - Diverted RM cell is not merged
// - Diverted cell keeps input CLP bit
// - Processor port cells use its discard threshold
// - Scope clear: append input port on all cells to processor port
module cell_diversion
  import divert_pkg::*;
#(
  parameter int DEPTH = divert_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cell descriptor in, from the translation stage
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [divert_pkg::PORT_W-1:0] in_port,
  input wire logic [11:0] in_vpi,
  input wire logic [15:0] in_vci,
  input wire logic [2:0] in_pti,
  input wire logic in_clp,
  input wire logic in_divert_to_cpu_flag,
  input wire logic in_vp_connection_flag,
  input wire logic in_user_chan,
  input wire logic in_rm_cell,
  input wire logic [divert_pkg::PORTS-1:0] in_dest,
  input wire logic [11:0] in_xvpi,
  input wire logic [15:0] in_xvci,
  // Queue length of the processor port
  input wire logic [divert_pkg::QLEN_W-1:0] cpu_queue_len,
  // Cell descriptor out, to the queue stage
  output logic out_valid,
  input wire logic out_ready,
  output logic [divert_pkg::PORTS-1:0] out_dest,
  output logic [11:0] out_vpi,
  output logic [15:0] out_vci,
  output logic [2:0] out_pti,
  output logic out_clp,
  output logic [divert_pkg::PORT_W-1:0] out_in_port,
  output logic out_append,
  output logic out_divert,
  output logic out_rm_hold,
  output logic out_cpu_discard
);
  import divert_pkg::*;

  localparam int LW = $clog2(DEPTH) + 1;

  // All registers of the block
  typedef struct packed {
    logic [PORT_W-1:0] cpu_port;   // cpu_port_number_field
    logic divert_en;
    logic append_scope;            // append_scope_select
    logic [2:0] payload_type_filter_value;               // payload_type_filter_value
    logic vc_only;                 // efci_vc_only_select
    logic [QLEN_W-1:0] efci_thr;
    logic [QLEN_W-1:0] disc_thr;
    logic [31:0] div_count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ovalid;
    logic [PORTS-1:0] dest;
    logic [11:0] vpi;
    logic [15:0] vci;
    logic [2:0] pti;
    logic clp;
    logic [PORT_W-1:0] in_port;
    logic append;
    logic divert;
    logic rm_hold;
    logic cpu_discard;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  cell_type wr_cell;    // Packed view of the input ports
  cell_type h;          // Cell at the buffer head
  logic head_valid;     // Buffer holds a cell
  logic take;           // Head moves into the output stage
  logic [LW-1:0] level; // Buffer fill level
  logic from_cpu;       // Head arrived on the processor port
  logic divert_c;       // Head meets a diversion condition
  logic congested;      // Processor port queue over EFCI threshold
  logic over_disc;      // Processor port queue over discard threshold
  logic [PORTS-1:0] cpu_mask;

  // Address decode, used by both read and write paths
  function automatic logic reg_hit(input logic [7:0] a);
    return a == ADDR_PORT_CFG || a == ADDR_FILTER || a == ADDR_MODE ||
      a == ADDR_EFCI_THR || a == ADDR_DISC_THR ||
      a == ADDR_DIV_COUNT || a == ADDR_STATUS;
  endfunction

  assign wr_cell = '{in_port: in_port, vpi: in_vpi, vci: in_vci,
    pti: in_pti, clp: in_clp, flag: in_divert_to_cpu_flag,
    vp_conn: in_vp_connection_flag, user_chan: in_user_chan,
    rm_cell: in_rm_cell, dest: in_dest, xvpi: in_xvpi, xvci: in_xvci};

  // Buffer between translation and decision; back-pressure reaches in_ready
  cell_fifo #(
    .WIDTH($bits(cell_type)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_data(wr_cell),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .rd_data(h),
    .rd_valid(head_valid),
    .rd_ready(take),
    .level(level)
  );

  // Output stage drains when empty or when the consumer accepts
  assign take = head_valid & (~s_r.ovalid | out_ready);

  // Diversion decision on the buffer head
  always_comb begin
    from_cpu = (h.in_port == s_r.cpu_port);
    divert_c = 1'b0;
    if (s_r.divert_en && !from_cpu) begin
      if (h.user_chan) begin
        // Filter match counts on VC connections only
        divert_c = ~h.vp_conn && (h.pti == s_r.payload_type_filter_value);
      end else begin
        divert_c = h.flag;
      end
    end
    cpu_mask = '0;
    cpu_mask[s_r.cpu_port] = 1'b1;
    congested = cpu_queue_len > s_r.efci_thr;
    over_disc = cpu_queue_len > s_r.disc_thr;
  end

  // Register file, APB answer and output stage
  always_comb begin
    s_nxt = s_r;
    // One wait cycle: pready rises on the first access edge
    s_nxt.pready = psel & penable & ~s_r.pready;
    s_nxt.pslverr = psel & penable & ~s_r.pready & ~reg_hit(paddr);
    s_nxt.prdata = '0;
    if (psel && penable && !s_r.pready && !pwrite) begin
      case (paddr)
        ADDR_PORT_CFG: begin
          s_nxt.prdata[CPU_PORT_LSB +: PORT_W] = s_r.cpu_port;
          s_nxt.prdata[DIVERT_EN_BIT] = s_r.divert_en;
          s_nxt.prdata[APPEND_SCOPE_BIT] = s_r.append_scope;
        end
        ADDR_FILTER: s_nxt.prdata[2:0] = s_r.payload_type_filter_value;
        ADDR_MODE: s_nxt.prdata[EFCI_VC_ONLY_BIT] = s_r.vc_only;
        ADDR_EFCI_THR: s_nxt.prdata[QLEN_W-1:0] = s_r.efci_thr;
        ADDR_DISC_THR: s_nxt.prdata[QLEN_W-1:0] = s_r.disc_thr;
        ADDR_DIV_COUNT: s_nxt.prdata = s_r.div_count;
        ADDR_STATUS: begin
          s_nxt.prdata[STAT_LEVEL_LSB +: LW] = level;
          s_nxt.prdata[STAT_CONG_BIT] = congested;
          s_nxt.prdata[STAT_OVER_BIT] = over_disc;
        end
        default: s_nxt.prdata = '0;
      endcase
    end
    // Writes land on the edge where pready is sampled high
    if (psel && penable && s_r.pready && pwrite) begin
      case (paddr)
        ADDR_PORT_CFG: begin
          s_nxt.cpu_port = pwdata[CPU_PORT_LSB +: PORT_W];
          s_nxt.divert_en = pwdata[DIVERT_EN_BIT];
          s_nxt.append_scope = pwdata[APPEND_SCOPE_BIT];
        end
        // Codes below 1xx are not meaningful filters; stored as written
        ADDR_FILTER: s_nxt.payload_type_filter_value = pwdata[2:0];
        ADDR_MODE: s_nxt.vc_only = pwdata[EFCI_VC_ONLY_BIT];
        ADDR_EFCI_THR: s_nxt.efci_thr = pwdata[QLEN_W-1:0];
        ADDR_DISC_THR: s_nxt.disc_thr = pwdata[QLEN_W-1:0];
        default: s_nxt.prdata = s_nxt.prdata;
      endcase
    end
    // Consumer took the held cell
    if (s_r.ovalid && out_ready) begin
      s_nxt.ovalid = 1'b0;
    end
    if (take) begin
      s_nxt.ovalid = 1'b1;
      s_nxt.in_port = h.in_port;
      s_nxt.clp = h.clp;
      s_nxt.divert = divert_c;
      s_nxt.pti = h.pti;
      if (divert_c) begin
        // Same mask for single cast and multicast: processor port alone
        s_nxt.dest = cpu_mask;
        s_nxt.vpi = h.vpi;
        s_nxt.vci = h.vci;
        // Congestion bit set on 0xx when the queue is past threshold
        if (congested && h.pti[2] == 1'b0 && (!s_r.vc_only || !h.vp_conn)) begin
          s_nxt.pti[PTI_EFCI_BIT] = 1'b1;
        end
        // Later stages must leave this RM cell alone
        s_nxt.rm_hold = h.rm_cell;
        s_nxt.append = 1'b1;
        s_nxt.div_count = s_r.div_count + 32'h0000_0001;
      end else begin
        s_nxt.dest = h.dest;
        s_nxt.vpi = h.xvpi;
        s_nxt.vci = h.xvci;
        s_nxt.rm_hold = 1'b0;
        s_nxt.append = h.dest[s_r.cpu_port] & ~s_r.append_scope;
      end
      // Only cells bound for the processor port see its threshold
      s_nxt.cpu_discard = (divert_c | h.dest[s_r.cpu_port]) & over_disc;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{cpu_port: CPU_PORT_RST, payload_type_filter_value: PTF_RST, efci_thr: EFCI_THR_RST,
        disc_thr: DISC_THR_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output comes straight from a state flop
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign out_valid = s_r.ovalid;
  assign out_dest = s_r.dest;
  assign out_vpi = s_r.vpi;
  assign out_vci = s_r.vci;
  assign out_pti = s_r.pti;
  assign out_clp = s_r.clp;
  assign out_in_port = s_r.in_port;
  assign out_append = s_r.append;
  assign out_divert = s_r.divert;
  assign out_rm_hold = s_r.rm_hold;
  assign out_cpu_discard = s_r.cpu_discard;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A cell handed to the output stage from a non-processor port
  sequence line_take;
    take && !from_cpu && s_r.divert_en;
  endsequence

  // APB access phase is answered one cycle later
  sequence apb_wait;
    psel && penable && !pready;
  endsequence

  chk_apb_answer: assert property (apb_wait |=> pready)
    else $error("APB access not answered after one wait cycle");

  chk_divert_mask: assert property (
    take && divert_c |=> out_divert && out_dest == $past(cpu_mask))
    else $error("Diverted cell not sent to processor port alone");

  chk_no_self_divert: assert property (
    take && h.in_port == s_r.cpu_port |=> !out_divert)
    else $error("Cell from processor port was diverted");

  chk_flag_divert: assert property (
    line_take ##0 (!h.user_chan && h.flag) |=> out_divert)
    else $error("Flagged pre-defined cell not diverted");

  chk_filter_divert: assert property (
    line_take ##0 (h.user_chan && !h.vp_conn && h.pti == s_r.payload_type_filter_value) |=> out_divert)
    else $error("Filter match on VC not diverted");

  chk_vp_no_filter: assert property (
    take && h.user_chan && h.vp_conn |=> !out_divert)
    else $error("User cell on VP connection diverted");

  chk_keep_header: assert property (
    take && divert_c |=> out_vpi == $past(h.vpi) && out_vci == $past(h.vci)
      && out_clp == $past(h.clp))
    else $error("Diverted cell header altered");

  chk_efci_mark: assert property (
    take && divert_c && congested && !s_r.vc_only && h.pti == 3'h0
      |=> out_pti == 3'h2)
    else $error("EFCI marking missing on diverted cell");

  chk_efci_vp_keep: assert property (
    take && divert_c && s_r.vc_only && h.vp_conn |=> out_pti == $past(h.pti))
    else $error("VP cell PTI changed with VC-only marking");

  chk_rm_hold: assert property (
    take && divert_c && h.rm_cell |=> out_rm_hold)
    else $error("Diverted RM cell not protected");

  chk_cpu_discard: assert property (
    take && divert_c |=> out_cpu_discard == $past(over_disc))
    else $error("Processor port threshold not applied");

  chk_append_all: assert property (
    take && !divert_c && h.dest[s_r.cpu_port] && !s_r.append_scope |=> out_append)
    else $error("Input port not appended on ordinary cell");

  chk_ordinary_pass: assert property (
    take && !divert_c |=> out_dest == $past(h.dest) && out_vpi == $past(h.xvpi)
      && out_pti == $past(h.pti))
    else $error("Ordinary cell modified");

  chk_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_dest))
    else $error("Output cell dropped before acceptance");

  // Filter code is stored exactly as software wrote it; range is software's duty
  chk_filter_store: assert property (
    psel && penable && pready && pwrite && paddr == ADDR_FILTER
      |=> s_r.payload_type_filter_value == $past(pwdata[2:0]))
    else $error("Filter code not stored as written");
endmodule

`default_nettype wire

// *** bench/cell_sink.sv ***
// Queue stage model that takes cells from the diversion block
`timescale 1ns/1ps
`default_nettype none

module cell_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic slow,
  output logic out_ready
);
  logic tog_r; // Alternates to halve the accept rate in slow mode

  // Ready is registered, so the block never sees it change mid-cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_r <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      out_ready <= !stall && (!slow || tog_r);
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_cell_diversion.sv ***
// Self-checking testbench for the cell diversion block
`timescale 1ns/1ps
`default_nettype none

module tb_cell_diversion;
  import divert_pkg::*;
  typedef logic [72:0] obs_type; // Packed view of one output cell
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, in_ready, out_valid, out_ready;
  logic in_valid = 1'b0;
  cell_type c_r = '0; // Descriptor offered at the input
  logic [QLEN_W-1:0] qlen = 16'h0000;
  logic stall = 1'b0, slow = 1'b0;
  logic [PORTS-1:0] out_dest;
  logic [11:0] out_vpi;
  logic [15:0] out_vci;
  logic [2:0] out_pti;
  logic out_clp, out_append, out_divert, out_rm_hold, out_cpu_discard;
  logic [PORT_W-1:0] out_in_port;
  // Reference copy of the programmed settings
  logic [4:0] cpu = 5'h00;
  logic en = 1'b0, scope = 1'b0, vco = 1'b0;
  logic [2:0] payload_type_filter_value = 3'h7;
  logic [15:0] ethr = 16'hFFFF, dthr = 16'hFFFF;
  logic [15:0] qv = 16'h0000; // Reference copy of the queue length driven on qlen
  int n_mismatch = 0, cmp_count = 0, n_div = 0;
  obs_type exp_q[$]; // Cells expected at the output, in order

  always #12.5 pclk = ~pclk;

  cell_diversion dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_port(c_r.in_port),
    .in_vpi(c_r.vpi), .in_vci(c_r.vci), .in_pti(c_r.pti), .in_clp(c_r.clp),
    .in_divert_to_cpu_flag(c_r.flag), .in_vp_connection_flag(c_r.vp_conn),
    .in_user_chan(c_r.user_chan), .in_rm_cell(c_r.rm_cell), .in_dest(c_r.dest),
    .in_xvpi(c_r.xvpi), .in_xvci(c_r.xvci), .cpu_queue_len(qlen), .out_valid(out_valid),
    .out_ready(out_ready), .out_dest(out_dest), .out_vpi(out_vpi), .out_vci(out_vci),
    .out_pti(out_pti), .out_clp(out_clp), .out_in_port(out_in_port),
    .out_append(out_append), .out_divert(out_divert), .out_rm_hold(out_rm_hold),
    .out_cpu_discard(out_cpu_discard));

  cell_sink sink_u (.pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
    .out_ready(out_ready));

  // Verdict and end of run
  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic fail(input string m);
    n_mismatch++;
    $display("Error at %0t: %s", $time, m);
  endtask

  // A wait that runs out ends the run
  task automatic tmo();
    fail("wait ran out");
    test_done();
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("word %h, want %h", got, exp));
  endtask

  task automatic cmp_cell(input obs_type got, input obs_type exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("cell %h, want %h", got, exp));
  endtask

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      if (++n > 50) tmo();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp32({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp32(r, x);
    cmp32({31'h0, e}, 32'h0);
  endtask

  task automatic cfg(input logic [4:0] cp, input logic e, input logic s);
    wr(ADDR_PORT_CFG, {22'h0, s, e, 3'h0, cp});
    cpu = cp;
    en = e;
    scope = s;
  endtask

  function automatic cell_type mk(input logic [4:0] p, input logic f, input logic vp,
      input logic u, input logic rm, input logic [2:0] t, input logic [31:0] d);
    cell_type c;
    c = '{p, 12'h0A5, 16'h1234, t, 1'b1, f, vp, u, rm, d, 12'h3C6, 16'h5E7};
    return c;
  endfunction

  // Expected output cell, worked out from the settings
  function automatic obs_type model(input cell_type c);
    logic d;
    logic [2:0] p;
    d = en && c.in_port != cpu && (c.user_chan ? (!c.vp_conn && c.pti == payload_type_filter_value) : c.flag);
    p = c.pti;
    if (d && !p[2] && qv > ethr && (!vco || !c.vp_conn)) p[1] = 1'b1;
    return {d ? (32'h1 << cpu) : c.dest, d ? c.vpi : c.xvpi, d ? c.vci : c.xvci, p,
      c.clp, c.in_port, d || (c.dest[cpu] && !scope), d, d && c.rm_cell,
      (d || c.dest[cpu]) && qv > dthr};
  endfunction

  // Offer one cell; valid stays high so cells can follow back to back
  task automatic send(input cell_type c);
    obs_type o;
    int n;
    o = model(c);
    exp_q.push_back(o);
    n_div += o[2];
    c_r <= c;
    in_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      if (++n > 50) tmo();
    end while (in_ready !== 1'b1);
  endtask

  task automatic drain();
    int n;
    in_valid <= 1'b0;
    n = 0;
    while (exp_q.size() > 0) begin
      @(posedge pclk);
      if (++n > 300) tmo();
    end
  endtask

  // Every accepted output cell is checked against the queue
  always @(posedge pclk) begin
    if (presetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected cell");
      else cmp_cell({out_dest, out_vpi, out_vci, out_pti, out_clp, out_in_port, out_append,
        out_divert, out_rm_hold, out_cpu_discard}, exp_q.pop_front());
    end
  end

  initial begin
    #2500000;
    fail("run limit");
    test_done();
  end

  initial begin
    cell_type c;
    logic [31:0] r;
    logic e;
    logic full;
    int n;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_PORT_CFG, 32'h0);
    rd(ADDR_FILTER, 32'h7);
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_EFCI_THR, 32'hFFFF);
    rd(ADDR_DISC_THR, 32'hFFFF);
    apb(1'b1, ADDR_DIV_COUNT, 32'h55, r, e);
    rd(ADDR_DIV_COUNT, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    cmp32(r, 32'h0);
    cmp32({31'h0, e}, 32'h1);
    $display("Test registers done");
    send(mk(1, 1, 0, 0, 0, 0, 32'h4));
    drain();
    cfg(5'd3, 1'b1, 1'b0);
    for (int i = 4; i < 8; i++) begin
      wr(ADDR_FILTER, i);
      payload_type_filter_value = 3'(i);
      send(mk(1, 0, 0, 1, 0, i, 32'h4));
      drain();
    end
    send(mk(1, 1, 0, 0, 0, 0, 32'h4));
    send(mk(2, 1, 0, 0, 0, 1, 32'h6));
    send(mk(1, 0, 1, 1, 0, 7, 32'h4));
    send(mk(1, 0, 0, 1, 0, 3, 32'h4));
    send(mk(3, 1, 0, 0, 0, 0, 32'h4));
    send(mk(1, 1, 0, 0, 1, 0, 32'h4));
    send(mk(1, 0, 0, 0, 0, 0, 32'h8));
    drain();
    rd(ADDR_DIV_COUNT, n_div);
    $display("Test diversion done");
    wr(ADDR_EFCI_THR, 32'hA);
    wr(ADDR_DISC_THR, 32'hA);
    ethr = 16'hA;
    dthr = 16'hA;
    qlen <= 16'hB;
    qv = 16'hB;
    send(mk(1, 1, 1, 0, 0, 0, 32'h4));
    send(mk(1, 1, 0, 0, 0, 1, 32'h4));
    drain();
    rd(ADDR_STATUS, 32'h300);
    wr(ADDR_MODE, 32'h1);
    vco = 1'b1;
    cfg(5'd9, 1'b1, 1'b1);
    send(mk(1, 1, 1, 0, 0, 1, 32'h4));
    send(mk(1, 1, 0, 0, 0, 0, 32'h4));
    send(mk(2, 0, 0, 0, 0, 0, 32'h200));
    send(mk(9, 1, 0, 0, 0, 0, 32'h4));
    drain();
    qlen <= 16'hA;
    qv = 16'hA;
    send(mk(1, 1, 0, 0, 0, 0, 32'h4));
    drain();
    $display("Test marking done");
    stall <= 1'b1;
    c = mk(1, 0, 0, 0, 0, 0, 32'h4);
    c.xvci = 16'h0;
    c_r <= c;
    in_valid <= 1'b1;
    n = 0;
    full = 1'b0;
    for (int i = 0; i < 40 && !full; i++) begin
      @(posedge pclk);
      if (in_ready === 1'b1) begin
        exp_q.push_back(model(c));
        n++;
        c.xvci = 16'(n);
        c_r <= c;
      end else full = 1'b1;
    end
    cmp32({31'h0, n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1}, 32'h1);
    stall <= 1'b0;
    slow <= 1'b1;
    drain();
    cmp32({31'h0, in_ready}, 32'h1);
    $display("Test buffer done");
    test_done();
  end
endmodule
`default_nettype wire
